// ==== fcpwm_top.sv ====
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module fcpwm_top #(
	parameter int NUM_CH = fcpwm_pkg::NUM_CH
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [3:0] i_pin_in,
	output logic [3:0] o_pin_out,
	output logic [3:0] o_pin_oe_n
);
	logic [7:0] clock_and_concat_q;
	logic [7:0] clock_select_polarity_q;
	logic [3:0] channel_enable_q;
	logic [7:0] align_control_q;
	logic [7:0] scale_a_q;
	logic [7:0] scale_b_q;
	logic [3:0] port_data_q;
	logic [3:0] port_direction_bits_q;
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [7:0] rdata_q;
	logic [3:0] pin_out_q;
	logic [3:0] pin_oe_n_q;

	logic [7:0] buf_per_q [NUM_CH];
	logic [7:0] buf_dty_q [NUM_CH];
	logic [7:0] act_per_q [NUM_CH];
	logic [7:0] act_dty_q [NUM_CH];
	logic [7:0] cnt_q [NUM_CH];
	logic up_q [NUM_CH];
	logic run_q [NUM_CH];
	logic wave_q [NUM_CH];

	logic wr_cnt [NUM_CH];
	logic wr_per [NUM_CH];
	logic wr_dty [NUM_CH];
	logic cnt_clr [NUM_CH];
	logic tick [NUM_CH];
	logic adv [NUM_CH];
	logic roll [NUM_CH];
	logic idle [NUM_CH];
	logic en_eff [NUM_CH];
	logic up_nx [NUM_CH];
	logic wav [NUM_CH];
	logic [7:0] cnt_nx [NUM_CH];
	logic [7:0] per_in [NUM_CH];
	logic [7:0] dty_in [NUM_CH];
	logic [3:0] run_vec;
	logic [3:0] drive_vec;

	logic tick_a;
	logic tick_b;
	logic tick_sa;
	logic tick_sb;
	logic center_align_select;
	logic join_lower_pair;
	logic join_upper_pair;
	logic [2:0] cnt_hit;
	logic [2:0] per_hit;
	logic [2:0] dty_hit;
	logic [7:0] rd_mux;
	logic load_a;
	logic load_b;
	logic [7:0] scale_a_in;
	logic [7:0] scale_b_in;

	// Returns {hit, index} for a block of four byte registers
	function automatic logic [2:0] grp_hit(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return {d < 8'h04, d[1:0]};
	endfunction

	// Returns {rollover, next direction, next count}
	function automatic logic [17:0] step(input logic [15:0] cnt, input logic [15:0] per,
		input logic up, input logic center);
		logic [15:0] inc;
		logic [15:0] dec;
		logic [17:0] r;
		inc = cnt + 16'h0001;
		dec = cnt - 16'h0001;
		r = {1'b0, up, inc};
		if (!center) begin
			if (cnt >= per) begin
				r = {1'b1, 1'b1, 16'h0000};
			end
		end else if (per == 16'h0000) begin
			r = {1'b1, 1'b1, 16'h0000};
		end else if (up) begin
			if (cnt >= per) begin
				r = {1'b0, 1'b0, dec};
			end
		end else begin
			r = {dec == 16'h0000, dec == 16'h0000, dec};
		end
		return r;
	endfunction

	assign join_upper_pair = clock_and_concat_q[fcpwm_pkg::JOIN_UPPER_PAIR_BIT];
	assign join_lower_pair = clock_and_concat_q[fcpwm_pkg::JOIN_LOWER_PAIR_BIT];
	assign center_align_select = align_control_q[fcpwm_pkg::CENTER_ALIGN_SELECT_BIT];
	assign cnt_hit = grp_hit(i_addr, fcpwm_pkg::OFF_COUNTER0);
	assign per_hit = grp_hit(i_addr, fcpwm_pkg::OFF_PERIOD0);
	assign dty_hit = grp_hit(i_addr, fcpwm_pkg::OFF_DUTY0);
	// Scaler reload takes the byte being written, not the register's old value
	assign load_a = i_wr && (i_addr == fcpwm_pkg::OFF_SCALE_A);
	assign load_b = i_wr && (i_addr == fcpwm_pkg::OFF_SCALE_B);
	assign scale_a_in = load_a ? i_wdata : scale_a_q;
	assign scale_b_in = load_b ? i_wdata : scale_b_q;

	// Keep the prescaler alive until every run gate has closed on a tick
	assign run_vec = {run_q[3], run_q[2], run_q[1], run_q[0]};

	fcpwm_clkgen #(
		.PRE_W(fcpwm_pkg::PRESCALE_W),
		.SC_W(fcpwm_pkg::SCALE_W)
	) u_clkgen (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_run((|channel_enable_q) | (|run_vec)),
		.i_pre_a(clock_and_concat_q[fcpwm_pkg::CLOCK_A_PRESCALE_LSB +: 3]),
		.i_pre_b(clock_and_concat_q[fcpwm_pkg::CLOCK_B_PRESCALE_LSB +: 3]),
		.i_scale_a(scale_a_in),
		.i_scale_b(scale_b_in),
		.i_load_a(load_a),
		.i_load_b(load_b),
		.o_tick_a(tick_a),
		.o_tick_b(tick_b),
		.o_tick_sa(tick_sa),
		.o_tick_sb(tick_sb)
	);

	for (genvar c = 0; c < NUM_CH; c++) begin : g_dec
		assign wr_cnt[c] = i_wr & cnt_hit[2] & (cnt_hit[1:0] == 2'(c));
		assign wr_per[c] = i_wr & per_hit[2] & (per_hit[1:0] == 2'(c));
		assign wr_dty[c] = i_wr & dty_hit[2] & (dty_hit[1:0] == 2'(c));
		assign per_in[c] = wr_per[c] ? i_wdata : buf_per_q[c];
		assign dty_in[c] = wr_dty[c] ? i_wdata : buf_dty_q[c];
	end

	// Pair p: channel 2p is the high byte, channel 2p+1 the low byte
	for (genvar p = 0; p < 2; p++) begin : g_pair
		localparam int H = 2 * p;
		localparam int L = 2 * p + 1;
		logic jn;
		logic base_tk;
		logic scaled_tk;
		logic sel_h;
		logic sel_l;
		logic [15:0] hc;
		logic [15:0] hp;
		logic [15:0] hd;
		logic [17:0] hs;
		logic [17:0] ls;

		assign jn = (p == 0) ? join_lower_pair : join_upper_pair;
		assign base_tk = (p == 0) ? tick_a : tick_b;
		assign scaled_tk = (p == 0) ? tick_sa : tick_sb;
		// Joined pair runs from the low channel's clock select
		assign sel_l = clock_select_polarity_q[fcpwm_pkg::SCALED_SELECT_LSB + L];
		assign sel_h = jn ? sel_l
			: clock_select_polarity_q[fcpwm_pkg::SCALED_SELECT_LSB + H];
		// Select is not retimed: a change mid-period may bend one pulse
		assign tick[H] = sel_h ? scaled_tk : base_tk;
		assign tick[L] = sel_l ? scaled_tk : base_tk;
		assign en_eff[H] = channel_enable_q[H];
		assign en_eff[L] = channel_enable_q[L] & ~jn;

		assign hc = jn ? {cnt_q[H], cnt_q[L]} : {8'h00, cnt_q[H]};
		assign hp = jn ? {act_per_q[H], act_per_q[L]} : {8'h00, act_per_q[H]};
		assign hd = jn ? {act_dty_q[H], act_dty_q[L]} : {8'h00, act_dty_q[H]};
		assign hs = step(hc, hp, up_q[H], center_align_select);
		assign ls = step({8'h00, cnt_q[L]}, {8'h00, act_per_q[L]}, up_q[L],
			center_align_select);

		assign adv[H] = run_q[H] & tick[H];
		assign adv[L] = jn ? adv[H] : run_q[L] & tick[L];
		assign roll[H] = adv[H] & hs[17];
		assign roll[L] = jn ? roll[H] : adv[L] & ls[17];
		assign cnt_nx[H] = jn ? hs[15:8] : hs[7:0];
		assign cnt_nx[L] = jn ? hs[7:0] : ls[7:0];
		assign up_nx[H] = hs[16];
		assign up_nx[L] = jn ? hs[16] : ls[16];
		assign idle[H] = ~en_eff[H];
		assign idle[L] = jn ? idle[H] : ~en_eff[L];
		// Writing either byte of a joined counter restarts the whole 16-bit count
		assign cnt_clr[H] = wr_cnt[H] | (jn & wr_cnt[L]);
		assign cnt_clr[L] = wr_cnt[L] | (jn & wr_cnt[H]);
		// Output sits at polarity until count passes duty
		assign wav[H] = clock_select_polarity_q[fcpwm_pkg::POLARITY_LSB + H]
			^ (hc > hd);
		assign wav[L] = clock_select_polarity_q[fcpwm_pkg::POLARITY_LSB + L]
			^ (cnt_q[L] > act_dty_q[L]);
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
		always_ff @(posedge i_ref_clk) begin
			if (i_rst) begin
				buf_per_q[c] <= fcpwm_pkg::PERIOD_RST;
				buf_dty_q[c] <= fcpwm_pkg::DUTY_RST;
				act_per_q[c] <= fcpwm_pkg::PERIOD_RST;
				act_dty_q[c] <= fcpwm_pkg::DUTY_RST;
				cnt_q[c] <= fcpwm_pkg::COUNTER_RST;
				up_q[c] <= 1'b1;
				run_q[c] <= 1'b0;
				wave_q[c] <= 1'b0;
			end else if (i_ce) begin
				if (wr_per[c]) begin
					buf_per_q[c] <= i_wdata;
				end
				if (wr_dty[c]) begin
					buf_dty_q[c] <= i_wdata;
				end
				if (cnt_clr[c]) begin
					cnt_q[c] <= fcpwm_pkg::COUNTER_RST;
					up_q[c] <= 1'b1;
					act_per_q[c] <= per_in[c];
					act_dty_q[c] <= dty_in[c];
				end else begin
					if (adv[c]) begin
						cnt_q[c] <= cnt_nx[c];
						up_q[c] <= up_nx[c];
					end
					if (roll[c] | idle[c]) begin
						act_per_q[c] <= per_in[c];
						act_dty_q[c] <= dty_in[c];
					end
				end
				// Gate opens and closes only on the channel's own tick
				if (tick[c]) begin
					run_q[c] <= en_eff[c];
				end
				wave_q[c] <= wav[c];
			end
		end
		assign drive_vec[c] = en_eff[c] & run_q[c];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			clock_and_concat_q <= fcpwm_pkg::CLOCK_AND_CONCAT_RST;
			clock_select_polarity_q <= fcpwm_pkg::CLOCK_SELECT_POLARITY_RST;
			channel_enable_q <= fcpwm_pkg::CHANNEL_ENABLE_RST;
			align_control_q <= fcpwm_pkg::ALIGN_CONTROL_RST;
			scale_a_q <= fcpwm_pkg::SCALE_RST;
			scale_b_q <= fcpwm_pkg::SCALE_RST;
			port_data_q <= fcpwm_pkg::PORT_DATA_RST;
			port_direction_bits_q <= fcpwm_pkg::PORT_DIRECTION_RST;
		end else if (i_ce && i_wr) begin
			case (i_addr)
				fcpwm_pkg::OFF_CLOCK_AND_CONCAT: begin
					clock_and_concat_q <= i_wdata;
				end
				fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY: begin
					clock_select_polarity_q <= i_wdata;
				end
				fcpwm_pkg::OFF_CHANNEL_ENABLE: begin
					channel_enable_q <= i_wdata[3:0];
				end
				fcpwm_pkg::OFF_ALIGN_CONTROL: begin
					align_control_q <= {7'h00, i_wdata[fcpwm_pkg::CENTER_ALIGN_SELECT_BIT]};
				end
				fcpwm_pkg::OFF_SCALE_A: begin
					scale_a_q <= i_wdata;
				end
				fcpwm_pkg::OFF_SCALE_B: begin
					scale_b_q <= i_wdata;
				end
				fcpwm_pkg::OFF_PORT_DATA: begin
					port_data_q <= i_wdata[3:0];
				end
				fcpwm_pkg::OFF_PORT_DIRECTION: begin
					port_direction_bits_q <= i_wdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (cnt_hit[2]) begin
			rd_mux = cnt_q[cnt_hit[1:0]];
		end else if (per_hit[2]) begin
			rd_mux = buf_per_q[per_hit[1:0]];
		end else if (dty_hit[2]) begin
			rd_mux = buf_dty_q[dty_hit[1:0]];
		end else begin
			case (i_addr)
				fcpwm_pkg::OFF_CLOCK_AND_CONCAT: rd_mux = clock_and_concat_q;
				fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY: rd_mux = clock_select_polarity_q;
				fcpwm_pkg::OFF_CHANNEL_ENABLE: rd_mux = {4'h0, channel_enable_q};
				fcpwm_pkg::OFF_ALIGN_CONTROL: rd_mux = align_control_q;
				fcpwm_pkg::OFF_SCALE_A: rd_mux = scale_a_q;
				fcpwm_pkg::OFF_SCALE_B: rd_mux = scale_b_q;
				fcpwm_pkg::OFF_PORT_DATA: rd_mux = {4'h0, pin_sync_q};
				fcpwm_pkg::OFF_PORT_DIRECTION: rd_mux = {4'h0, port_direction_bits_q};
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// Pins are synchronised before software sees them
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			rdata_q <= 8'h00;
			pin_out_q <= 4'h0;
			pin_oe_n_q <= 4'hf;
		end else if (i_ce) begin
			pin_meta_q <= i_pin_in;
			pin_sync_q <= pin_meta_q;
			rdata_q <= i_rd ? rd_mux : 8'h00;
			for (int c = 0; c < NUM_CH; c++) begin
				pin_out_q[c] <= drive_vec[c] ? wave_q[c] : port_data_q[c];
				pin_oe_n_q[c] <= ~(en_eff[c] | port_direction_bits_q[c]);
			end
		end
	end

	assign o_rdata = rdata_q;
	assign o_pin_out = pin_out_q;
	assign o_pin_oe_n = pin_oe_n_q;
endmodule
`default_nettype wire

// ==== fcpwm_pkg.sv ====
package fcpwm_pkg;
	localparam int NUM_CH = 4;
	localparam int DATA_W = 8;
	localparam int PRESCALE_W = 7;
	localparam int SCALE_W = 8;
	localparam int PRE_CODE_W = 3;

	localparam logic [7:0] OFF_CLOCK_AND_CONCAT = 8'h40;
	localparam logic [7:0] OFF_CLOCK_SELECT_POLARITY = 8'h41;
	localparam logic [7:0] OFF_CHANNEL_ENABLE = 8'h42;
	localparam logic [7:0] OFF_ALIGN_CONTROL = 8'h43;
	localparam logic [7:0] OFF_SCALE_A = 8'h44;
	localparam logic [7:0] OFF_SCALE_B = 8'h45;
	localparam logic [7:0] OFF_PORT_DATA = 8'h46;
	localparam logic [7:0] OFF_PORT_DIRECTION = 8'h47;
	localparam logic [7:0] OFF_COUNTER0 = 8'h48;
	localparam logic [7:0] OFF_PERIOD0 = 8'h4c;
	localparam logic [7:0] OFF_DUTY0 = 8'h50;

	localparam int JOIN_UPPER_PAIR_BIT = 7;
	localparam int JOIN_LOWER_PAIR_BIT = 6;
	localparam int CLOCK_A_PRESCALE_LSB = 3;
	localparam int CLOCK_B_PRESCALE_LSB = 0;
	localparam int SCALED_SELECT_LSB = 4;
	localparam int POLARITY_LSB = 0;
	localparam int CENTER_ALIGN_SELECT_BIT = 0;

	localparam logic [7:0] CLOCK_AND_CONCAT_RST = 8'h00;
	localparam logic [7:0] CLOCK_SELECT_POLARITY_RST = 8'h00;
	localparam logic [3:0] CHANNEL_ENABLE_RST = 4'h0;
	localparam logic [7:0] ALIGN_CONTROL_RST = 8'h00;
	localparam logic [7:0] SCALE_RST = 8'h00;
	localparam logic [3:0] PORT_DATA_RST = 4'h0;
	localparam logic [3:0] PORT_DIRECTION_RST = 4'h0;
	localparam logic [7:0] COUNTER_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [7:0] DUTY_RST = 8'hff;
endpackage

// ==== fcpwm_clkgen.sv ====
`timescale 1ns/10ps
`default_nettype none
module fcpwm_clkgen #(
	parameter int PRE_W = fcpwm_pkg::PRESCALE_W,
	parameter int SC_W = fcpwm_pkg::SCALE_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic [2:0] i_pre_a,
	input wire logic [2:0] i_pre_b,
	input wire logic [SC_W-1:0] i_scale_a,
	input wire logic [SC_W-1:0] i_scale_b,
	input wire logic i_load_a,
	input wire logic i_load_b,
	output logic o_tick_a,
	output logic o_tick_b,
	output logic o_tick_sa,
	output logic o_tick_sb
);
	logic [PRE_W-1:0] pre_q;
	logic [SC_W-1:0] scnt_q [2];
	logic half_q [2];
	logic src_tick [2];
	logic [SC_W-1:0] scale [2];
	logic load [2];
	logic stick [2];

	function automatic logic pre_hit(input logic [PRE_W-1:0] cnt, input logic [2:0] code);
		logic [PRE_W-1:0] m;
		m = ~({PRE_W{1'b1}} << code);
		return (cnt & m) == m;
	endfunction

	// Prescaler halts and clears while nothing runs, saving power
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pre_q <= '0;
		end else if (i_ce) begin
			pre_q <= i_run ? pre_q + 1'b1 : '0;
		end
	end

	assign o_tick_a = i_run & pre_hit(pre_q, i_pre_a);
	assign o_tick_b = i_run & pre_hit(pre_q, i_pre_b);
	assign src_tick[0] = o_tick_a;
	assign src_tick[1] = o_tick_b;
	assign scale[0] = i_scale_a;
	assign scale[1] = i_scale_b;
	assign load[0] = i_load_a;
	assign load[1] = i_load_b;

	// Down counter reloads at zero; every second reload gives one scaled tick
	for (genvar g = 0; g < 2; g++) begin : g_scaler
		always_ff @(posedge i_ref_clk) begin
			if (i_rst) begin
				scnt_q[g] <= '0;
				half_q[g] <= 1'b0;
			end else if (i_ce) begin
				if (load[g]) begin
					scnt_q[g] <= scale[g];
					half_q[g] <= 1'b0;
				end else if (src_tick[g]) begin
					if (scnt_q[g] == '0) begin
						scnt_q[g] <= scale[g];
						half_q[g] <= ~half_q[g];
					end else begin
						scnt_q[g] <= scnt_q[g] - 1'b1;
					end
				end
			end
		end
		assign stick[g] = src_tick[g] & (scnt_q[g] == '0) & half_q[g];
	end

	assign o_tick_sa = stick[0];
	assign o_tick_sb = stick[1];
endmodule
`default_nettype wire

// ==== fcpwm_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module fcpwm_props (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [3:0] i_pin_in,
	input wire logic [3:0] o_pin_out,
	input wire logic [3:0] o_pin_oe_n
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	wire logic unmapped = (i_addr < 8'h40) || (i_addr > 8'h53);
	wire logic en_set0 = i_wr && (i_addr == fcpwm_pkg::OFF_CHANNEL_ENABLE) && i_wdata[0];

	// Write strobe straight followed by a read of the same place
	sequence wr_then_rd(logic [7:0] a);
		(i_wr && i_addr == a) ##1 (i_rd && i_addr == a);
	endsequence

	rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	reset_state_a: assert property ($fell(i_rst) |-> o_pin_oe_n == 4'hf && o_pin_out == 4'h0)
		else $error("pins not released after reset");
	unmapped_zero_a: assert property (i_rd && unmapped |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property (wr_then_rd(fcpwm_pkg::OFF_CLOCK_AND_CONCAT) |=> o_rdata == $past(i_wdata, 2))
		else $error("clock register read back wrong");
	pol_readback_a: assert property (wr_then_rd(fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY) |=> o_rdata == $past(i_wdata, 2))
		else $error("select register read back wrong");
	en_readback_a: assert property (wr_then_rd(fcpwm_pkg::OFF_CHANNEL_ENABLE) |=> o_rdata == ($past(i_wdata, 2) & 8'h0f))
		else $error("enable register read back wrong");
	enable_drive_a: assert property (en_set0 |-> ##2 !o_pin_oe_n[0])
		else $error("enabled channel does not drive its pin");
	// Pin direction only moves as a result of a register write
	oe_stable_a: assert property (!$past(i_wr) && !$past(i_wr, 2) && !$past(i_wr, 3) |-> $stable(o_pin_oe_n))
		else $error("pin direction moved without a write");
endmodule
`default_nettype wire

// ==== fcpwm_pin_loads.sv ====
`timescale 1ns/10ps
`default_nettype none
module fcpwm_pin_loads (
	input wire logic [3:0] i_pin_out,
	input wire logic [3:0] i_pin_oe_n,
	output logic [3:0] o_pin_in
);
	// A released pin shows the inverse of its latch, so ignoring direction is caught
	assign o_pin_in = i_pin_out ^ i_pin_oe_n;
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ce = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	wire logic [7:0] o_rdata;
	wire logic [3:0] pin_in;
	wire logic [3:0] pin_out;
	wire logic [3:0] oe_n;
	int err_count = 0;
	int checks_done = 0;
	int k;

	fcpwm_top u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_in),
		.o_pin_out(pin_out), .o_pin_oe_n(oe_n));
	fcpwm_pin_loads u_loads (.i_pin_out(pin_out), .i_pin_oe_n(oe_n), .o_pin_in(pin_in));

	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got);
			err_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	// Read answer stands one cycle only, so it is caught mid-cycle
	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		chk(name, {8'h00, exp}, {8'h00, o_rdata});
	endtask

	task automatic wr_rd(input string name, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		chk(name, {8'h00, exp}, {8'h00, o_rdata});
	endtask

	// Length of the next whole stretch at level lvl on pin ch
	task automatic meas(input int ch, input logic lvl, output int n);
		int t;
		n = 0;
		for (t = 0; t < 5000 && pin_out[ch] !== ~lvl; t++) @(negedge i_ref_clk);
		for (t = 0; t < 5000 && pin_out[ch] !== lvl; t++) @(negedge i_ref_clk);
		for (t = 0; t < 5000 && pin_out[ch] === lvl; t++) begin
			n++;
			@(negedge i_ref_clk);
		end
	endtask

	// Period 3, duty 0, set up while disabled, counter cleared before enable
	task automatic run(input int ch, input logic [7:0] clk_v, input logic [7:0] pol_v, input logic lvl,
		input logic [15:0] exp);
		int n;
		wr(fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'h00);
		wr(fcpwm_pkg::OFF_CLOCK_AND_CONCAT, clk_v);
		wr(fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY, pol_v);
		wr(fcpwm_pkg::OFF_PERIOD0 + 8'(ch), 8'h03);
		wr(fcpwm_pkg::OFF_DUTY0 + 8'(ch), 8'h00);
		wr(fcpwm_pkg::OFF_COUNTER0 + 8'(ch), 8'h00);
		wr(fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'(1 << ch));
		meas(ch, lvl, n);
		meas(ch, lvl, n);
		chk("pulse length", exp, 16'(n));
	endtask

	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rchk("clock reg reset", fcpwm_pkg::OFF_CLOCK_AND_CONCAT, 8'h00);
		rchk("select reg reset", fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY, 8'h00);
		rchk("enable reg reset", fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'h00);
		rchk("period reset", fcpwm_pkg::OFF_PERIOD0, 8'hff);
		rchk("duty reset", fcpwm_pkg::OFF_DUTY0, 8'hff);
		wr_rd("clock reg", fcpwm_pkg::OFF_CLOCK_AND_CONCAT, 8'ha5, 8'ha5);
		wr_rd("select reg", fcpwm_pkg::OFF_CLOCK_SELECT_POLARITY, 8'h5a, 8'h5a);
		wr_rd("enable reg", fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'hf0, 8'h00);
		wr_rd("unmapped", 8'h60, 8'h77, 8'h00);
		$display("test registers done");
		for (k = 0; k < 8; k++) begin
			run(0, 8'(k << 3), 8'h00, 1'b1, 16'(3 << k));
			run(2, 8'(k), 8'h04, 1'b1, 16'(1 << k));
		end
		$display("test prescalers done");
		wr(fcpwm_pkg::OFF_SCALE_A, 8'h00);
		run(1, 8'h00, 8'h20, 1'b1, 16'd6);
		wr(fcpwm_pkg::OFF_SCALE_A, 8'hff);
		run(0, 8'h00, 8'h10, 1'b1, 16'd1536);
		wr(fcpwm_pkg::OFF_SCALE_B, 8'h02);
		run(3, 8'h00, 8'h80, 1'b1, 16'd18);
		$display("test scaled clocks done");
		run(0, 8'h40, 8'h00, 1'b1, 16'd771);
		wr(fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'h03);
		repeat (4) @(negedge i_ref_clk);
		chk("pin 1 free when joined", 16'h1, 16'(oe_n[1]));
		run(2, 8'h80, 8'h00, 1'b1, 16'd771);
		wr(fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'h0c);
		repeat (4) @(negedge i_ref_clk);
		chk("pin 3 free when joined", 16'h1, 16'(oe_n[3]));
		$display("test joined pairs done");
		wr(fcpwm_pkg::OFF_ALIGN_CONTROL, 8'h01);
		run(0, 8'h00, 8'h00, 1'b1, 16'd5);
		wr(fcpwm_pkg::OFF_ALIGN_CONTROL, 8'h00);
		$display("test center align done");
		run(0, 8'h00, 8'h00, 1'b1, 16'd3);
		wr(fcpwm_pkg::OFF_DUTY0, 8'h02);
		meas(0, 1'b1, k);
		meas(0, 1'b1, k);
		chk("buffered duty", 16'd1, 16'(k));
		$display("test buffered duty done");
		wr(fcpwm_pkg::OFF_PORT_DIRECTION, 8'h02);
		wr(fcpwm_pkg::OFF_PORT_DATA, 8'h02);
		repeat (4) @(negedge i_ref_clk);
		chk("pin drive", 16'hc, 16'(oe_n));
		chk("gpio out", 16'h1, 16'(pin_out[1]));
		rchk("direction kept", fcpwm_pkg::OFF_PORT_DIRECTION, 8'h02);
		wr(fcpwm_pkg::OFF_CHANNEL_ENABLE, 8'h00);
		repeat (4) @(negedge i_ref_clk);
		chk("pin released", 16'hd, 16'(oe_n));
		wr(fcpwm_pkg::OFF_PORT_DATA, 8'h00);
		repeat (4) @(negedge i_ref_clk);
		rchk("pin inputs", fcpwm_pkg::OFF_PORT_DATA, 8'h0d);
		$display("test port pins done");
		final_report();
	end

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		err_count++;
		final_report();
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
endmodule

bind fcpwm_top fcpwm_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire
